// *** logic/page_table.v ***
// System page table: associative page descriptors, registered lookup
`timescale 1ns/1ps
`default_nettype none
`include "vap_consts.vh"
module page_table (
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire i_we,
  input wire [`PT_IDX_W-1:0] i_widx,
  input wire i_wvalid,
  input wire [`VPN_W-1:0] i_wvpn,
  input wire [`FRM_W-1:0] i_wframe,
  input wire [`VPN_W-1:0] i_vpn,
  output reg o_hit,
  output reg [`FRM_W-1:0] o_frame
);
  reg [`PT_N-1:0] valid;
  reg [`VPN_W-1:0] vpn [0:`PT_N-1];
  reg [`FRM_W-1:0] frame [0:`PT_N-1];
  reg next_hit;
  reg [`FRM_W-1:0] next_frame;
  integer i;
  always @*
  begin
    next_hit = 1'b0;
    next_frame = {`FRM_W{1'b0}};
    for (i = 0; i < `PT_N; i = i + 1)
    begin
      if (valid[i] && vpn[i] == i_vpn)
      begin
        next_hit = 1'b1;
        next_frame = frame[i];
      end
    end
  end
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      valid <= {`PT_N{1'b0}};
      o_hit <= 1'b0;
      o_frame <= {`FRM_W{1'b0}};
    end
    else if (i_ce)
    begin
      if (i_we)
      begin
        valid[i_widx] <= i_wvalid;
        vpn[i_widx] <= i_wvpn;
        frame[i_widx] <= i_wframe;
      end
      o_hit <= next_hit;
      o_frame <= next_frame;
    end
  end
endmodule
`default_nettype wire

// *** logic/seg_desc_mem.v ***
// Segment descriptor memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "vap_consts.vh"
module seg_desc_mem (
  input wire i_clk,
  input wire i_ce,
  input wire i_we,
  input wire [`SEG_W-1:0] i_waddr,
  input wire [`DESC_W-1:0] i_wdata,
  input wire [`SEG_W-1:0] i_raddr,
  output reg [`DESC_W-1:0] o_rdata
);
  reg [`DESC_W-1:0] mem [0:`SEGS-1];
  always @(posedge i_clk)
  begin
    if (i_ce)
    begin
      if (i_we)
        mem[i_waddr] <= i_wdata;
      o_rdata <= mem[i_raddr];
    end
  end
endmodule
`default_nettype wire

// *** logic/vap_consts.vh ***
// Constants for the virtual address protection block
`ifndef VAP_CONSTS_VH
`define VAP_CONSTS_VH
// Register byte addresses
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_MASK 8'h08
`define A_FINFO 8'h0C
`define A_DLO 8'h10
`define A_DHI 8'h14
`define A_DIDX 8'h18
`define A_PVPN 8'h1C
`define A_PFRM 8'h20
// Widths
`define SEG_W 12
`define SEGS 4096
`define OFF_W 31
`define SYS_W 16
`define SVA_W 47
`define VPN_W 36
`define FRM_W 17
`define RMA_W 28
`define RING_W 4
`define KEY_W 6
`define DESC_W 48
`define PT_IDX_W 4
`define PT_N 16
// Page size: byte shift of the smallest page
`define PS_BASE 6'd11
// Descriptor fields: low word, then D_SYS in the high word
`define D_RD 3:0
`define D_WR 7:4
`define D_EX 11:8
`define D_CL 15:12
`define D_LOCK 21:16
`define D_R 24
`define D_W 25
`define D_X 26
`define D_VALID 31
`define D_SYS 47:32
// Page frame register fields
`define P_FRM 16:0
`define P_IDX 23:20
`define P_VHI 27:24
`define P_VALID 31
// Control register fields
`define C_PS 1:0
`define C_LOCK 2
// Access types
`define T_RD 2'h0
`define T_WR 2'h1
`define T_EX 2'h2
`define T_CL 2'h3
// Status bits
`define ST_DONE 0
`define ST_AFLT 1
`define ST_PFLT 2
`define ST_W 3
// Fault causes
`define F_NONE 3'h0
`define F_DESC 3'h1
`define F_ATTR 3'h2
`define F_RING 3'h3
`define F_KEY 3'h4
`define F_PAGE 3'h5
`endif

// *** logic/virtual_address_protection.v ***
// Two-step address translation with attribute, ring and key checks
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "vap_consts.vh"
// Notes on behaviour
// - Up to 4096 segments per process, picked by the segment field.
// - Byte offset is 31 bits, covering a 2048M byte segment.
// - Page size set once after reset, then locked until next reset.
// - Page size code picks 2K, 4K, 8K or 16K; it splits page and offset.
// - Each page maps onto one page frame of the same size.
// - Translate process address to system address, then to real address.
// - Step one reads the segment descriptor and checks privilege.
// - Step two looks up the system page table for the real address.
// - All checks must pass; any failure faults the process.
// - Descriptor has independent read, write and execute flags.
// - Reference type must match a set flag of the segment.
// - Flags are checked in step one only, never in the page step.
// - Fifteen rings, numbered 1 to 15; ring 0 is refused.
// - Lower ring number means more privilege.
// - Tables and page size are writable only in monitor mode.
// - Four brackets per segment: read, write, execute, call.
// - A nonzero lock must equal the presented key exactly.
module virtual_address_protection (
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_monitor_mode,
  input wire i_req_valid,
  input wire [`SEG_W-1:0] i_req_seg,
  input wire [`OFF_W-1:0] i_req_off,
  input wire [1:0] i_req_type,
  input wire [`RING_W-1:0] i_req_ring,
  input wire [`KEY_W-1:0] i_req_key,
  output wire o_req_ready,
  output reg o_done,
  output reg o_fault,
  output reg o_page_fault,
  output reg [`SVA_W-1:0] o_sva,
  output reg [`RMA_W-1:0] o_rma,
  output wire o_irq
);
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_SEG = 4'h2;
  localparam [3:0] S_PAGE = 4'h4;
  localparam [3:0] S_FIN = 4'h8;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [1:0] page_size;
  reg ps_locked;
  reg [`ST_W-1:0] status;
  reg [`ST_W-1:0] mask;
  reg [`ST_W-1:0] next_status;
  reg [2:0] fault_cause;
  reg [`SEG_W-1:0] fault_seg;
  reg [31:0] desc_lo;
  reg [`SYS_W-1:0] desc_hi;
  reg [31:0] pt_vpn_lo;
  reg [`SEG_W-1:0] cur_seg;
  reg [`OFF_W-1:0] cur_off;
  reg [1:0] cur_type;
  reg [`RING_W-1:0] cur_ring;
  reg [`KEY_W-1:0] cur_key;
  reg [`SVA_W-1:0] system_virtual_address;
  reg [2:0] next_cause;
  reg [31:0] next_rdata;
  wire [`DESC_W-1:0] desc;
  wire pt_hit;
  wire [`FRM_W-1:0] pt_frame;
  wire desc_we;
  wire pt_we;
  wire bus_wr_ok;

  // Splits a system address into its page number
  function [`VPN_W-1:0] page_num;
    input [`SVA_W-1:0] s;
    input [1:0] ps;
    reg [`SVA_W-1:0] t;
    begin
      t = s >> (`PS_BASE + {4'h0, ps});
      page_num = t[`VPN_W-1:0];
    end
  endfunction

  // Joins a frame number with the in-page offset
  function [`RMA_W-1:0] form_rma;
    input [`FRM_W-1:0] f;
    input [`SVA_W-1:0] s;
    input [1:0] ps;
    reg [`RMA_W-1:0] hi;
    reg [`RMA_W-1:0] lo_mask;
    begin
      hi = {{(`RMA_W-`FRM_W){1'b0}}, f} << (`PS_BASE + {4'h0, ps});
      lo_mask = ~({`RMA_W{1'b1}} << (`PS_BASE + {4'h0, ps}));
      form_rma = hi | (s[`RMA_W-1:0] & lo_mask);
    end
  endfunction

  // Privilege check of one reference against a descriptor
  function [2:0] check_access;
    input [31:0] d;
    input [1:0] typ;
    input [`RING_W-1:0] ring;
    input [`KEY_W-1:0] key;
    reg flag_ok;
    reg [`RING_W-1:0] bracket;
    begin
      case (typ)
        `T_RD:
        begin
          flag_ok = d[`D_R];
          bracket = d[`D_RD];
        end
        `T_WR:
        begin
          flag_ok = d[`D_W];
          bracket = d[`D_WR];
        end
        `T_EX:
        begin
          flag_ok = d[`D_X];
          bracket = d[`D_EX];
        end
        default:
        begin
          flag_ok = d[`D_X];
          bracket = d[`D_CL];
        end
      endcase
      // ring zero is outside the range
      if (!d[`D_VALID] || ring == {`RING_W{1'b0}})
        check_access = `F_DESC;
      else if (!flag_ok)
        check_access = `F_ATTR;
      else if (ring > bracket)
        check_access = `F_RING;
      else if (d[`D_LOCK] != {`KEY_W{1'b0}} && d[`D_LOCK] != key)
        check_access = `F_KEY;
      else
        check_access = `F_NONE;
    end
  endfunction

  // tables only written in monitor mode
  assign bus_wr_ok = i_wr && i_monitor_mode;
  assign desc_we = bus_wr_ok && i_addr == `A_DIDX;
  assign pt_we = bus_wr_ok && i_addr == `A_PFRM;
  // no translation until page size is set
  assign o_req_ready = state == S_IDLE && ps_locked;
  assign o_irq = |(status & mask);

  // segment field picks one of 4096 descriptors
  seg_desc_mem u_seg_desc_mem (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_we(desc_we),
    .i_waddr(i_wdata[`SEG_W-1:0]),
    .i_wdata({desc_hi, desc_lo}),
    .i_raddr(i_req_seg),
    .o_rdata(desc)
  );

  page_table u_page_table (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_we(pt_we),
    .i_widx(i_wdata[`P_IDX]),
    .i_wvalid(i_wdata[`P_VALID]),
    .i_wvpn({i_wdata[`P_VHI], pt_vpn_lo}),
    .i_wframe(i_wdata[`P_FRM]),
    .i_vpn(page_num(system_virtual_address, page_size)),
    .o_hit(pt_hit),
    .o_frame(pt_frame)
  );

  always @*
  begin
    next_cause = check_access(desc[31:0], cur_type, cur_ring, cur_key);
  end

  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (i_req_valid && ps_locked)
          next_state = S_SEG;
      end
      S_SEG:
      begin
        // any failed check ends the access
        if (next_cause != `F_NONE)
          next_state = S_IDLE;
        else
          next_state = S_PAGE;
      end
      S_PAGE:
        next_state = S_FIN;
      S_FIN:
        next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
  end

  always @*
  begin
    next_status = status;
    if (i_rd && i_addr == `A_STAT)
      next_status = {`ST_W{1'b0}};
    if (state == S_SEG && next_cause != `F_NONE)
      next_status[`ST_AFLT] = 1'b1;
    if (state == S_FIN && pt_hit)
      next_status[`ST_DONE] = 1'b1;
    if (state == S_FIN && !pt_hit)
      next_status[`ST_PFLT] = 1'b1;
  end

  always @*
  begin
    next_rdata = 32'h00000000;
    case (i_addr)
      `A_CTRL:
        next_rdata = {29'h0, ps_locked, page_size};
      `A_STAT:
        next_rdata = {29'h0, status};
      `A_MASK:
        next_rdata = {29'h0, mask};
      `A_FINFO:
        next_rdata = {13'h0, fault_cause, 4'h0, fault_seg};
      `A_DLO:
        next_rdata = desc_lo;
      `A_DHI:
        next_rdata = {16'h0, desc_hi};
      `A_PVPN:
        next_rdata = pt_vpn_lo;
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      state <= S_IDLE;
      page_size <= 2'h0;
      ps_locked <= 1'b0;
      status <= {`ST_W{1'b0}};
      mask <= {`ST_W{1'b0}};
      fault_cause <= `F_NONE;
      fault_seg <= {`SEG_W{1'b0}};
      desc_lo <= 32'h00000000;
      desc_hi <= {`SYS_W{1'b0}};
      pt_vpn_lo <= 32'h00000000;
      cur_seg <= {`SEG_W{1'b0}};
      cur_off <= {`OFF_W{1'b0}};
      cur_type <= `T_RD;
      cur_ring <= {`RING_W{1'b0}};
      cur_key <= {`KEY_W{1'b0}};
      system_virtual_address <= {`SVA_W{1'b0}};
      o_rdata <= 32'h00000000;
      o_done <= 1'b0;
      o_fault <= 1'b0;
      o_page_fault <= 1'b0;
      o_sva <= {`SVA_W{1'b0}};
      o_rma <= {`RMA_W{1'b0}};
    end
    else if (i_ce)
    begin
      state <= next_state;
      status <= next_status;
      o_done <= 1'b0;
      o_fault <= 1'b0;
      o_page_fault <= 1'b0;
      if (i_rd)
        o_rdata <= next_rdata;
      else
        o_rdata <= 32'h00000000;
      if (i_wr && i_addr == `A_MASK)
        mask <= i_wdata[`ST_W-1:0];
      if (bus_wr_ok && i_addr == `A_CTRL && !ps_locked && i_wdata[`C_LOCK])
      begin
        page_size <= i_wdata[`C_PS];
        ps_locked <= 1'b1;
      end
      if (bus_wr_ok && i_addr == `A_DLO)
        desc_lo <= i_wdata;
      if (bus_wr_ok && i_addr == `A_DHI)
        desc_hi <= i_wdata[`SYS_W-1:0];
      if (bus_wr_ok && i_addr == `A_PVPN)
        pt_vpn_lo <= i_wdata;
      if (state == S_IDLE && i_req_valid && ps_locked)
      begin
        cur_seg <= i_req_seg;
        cur_off <= i_req_off;
        cur_type <= i_req_type;
        cur_ring <= i_req_ring;
        cur_key <= i_req_key;
      end
      if (state == S_SEG)
      begin
        // flags used only in this step
        if (next_cause != `F_NONE)
        begin
          o_fault <= 1'b1;
          fault_cause <= next_cause;
          fault_seg <= cur_seg;
        end
        else
        begin
          // first step forms the system address
          system_virtual_address <= {desc[`D_SYS], cur_off};
        end
      end
      // second step forms the real address
      if (state == S_FIN)
      begin
        o_sva <= system_virtual_address;
        if (pt_hit)
        begin
          o_done <= 1'b1;
          // frame of the same page size
          o_rma <= form_rma(pt_frame, system_virtual_address, page_size);
        end
        else
        begin
          // missing page raises a page fault
          o_page_fault <= 1'b1;
          fault_cause <= `F_PAGE;
          fault_seg <= cur_seg;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/cpu_side_model.sv ***
// Processor side: holds each request until it is taken
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [54:0] i_cmd,
  input wire logic i_ready,
  output logic o_valid,
  output logic [54:0] o_cmd
);
  initial o_valid = 1'h0;
  initial o_cmd = 55'h0;
  always @(posedge i_clk)
  begin
    if (i_go)
    begin
      o_valid <= 1'h1;
      o_cmd <= i_cmd;
    end
    else if (o_valid && i_ready)
    begin
      o_valid <= 1'h0;
      o_cmd <= ~o_cmd;
    end
  end
endmodule
`default_nettype wire

// *** verif/test_virtual_address_protection.sv ***
// Self-checking bench for the translation block
`timescale 1ns/1ps
`default_nettype none
`include "vap_consts.vh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_virtual_address_protection;
  logic i_clk = 1'h0, i_resetn = 1'h0, i_wr = 1'h0, i_rd = 1'h0, mon = 1'h0, go = 1'h0, ce = 1'h1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [54:0] cmd = 55'h0;
  wire [54:0] req;
  wire [31:0] o_rdata;
  wire [`SVA_W-1:0] o_sva;
  wire [`RMA_W-1:0] o_rma;
  wire valid, ready, o_done, o_fault, o_page_fault, o_irq;
  int n_errors = 0, n_checks = 0, ps;
  always #4 i_clk = ~i_clk;
  virtual_address_protection dut (.i_clk, .i_resetn, .i_ce(ce), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_monitor_mode(mon), .i_req_valid(valid), .i_req_seg(req[54:43]), .i_req_off(req[42:12]),
    .i_req_type(req[11:10]), .i_req_ring(req[9:6]), .i_req_key(req[5:0]), .o_req_ready(ready), .o_done,
    .o_fault, .o_page_fault, .o_sva, .o_rma, .o_irq);
  cpu_side_model cpu (.i_clk, .i_go(go), .i_cmd(cmd), .i_ready(ready), .o_valid(valid), .o_cmd(req));
  task automatic conclude();
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clk);
    i_wr <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1 `CHK("rdata", e, o_rdata)
    @(posedge i_clk);
  endtask
  task automatic map(input logic [3:0] ix, input logic [15:0] sy, input logic [30:0] off, input logic [16:0] f);
    logic [35:0] vpn;
    vpn = 36'({sy, off} >> (11 + ps));
    wr(`A_PVPN, vpn[31:0]);
    wr(`A_PFRM, {1'h1, 3'h0, vpn[35:32], ix, 3'h0, f});
  endtask
  task automatic xl(input logic [11:0] s, input logic [30:0] off, input logic [1:0] t, input logic [3:0] r,
      input logic [5:0] k, input logic [2:0] c);
    logic [15:0] sy;
    logic [27:0] real_memory_address;
    int i;
    sy = (s == 12'h005) ? 16'h0123 : 16'hFEDC;
    real_memory_address = 28'((64'((s == 12'h005) ? 3 : 5) << (11 + ps)) | (64'(off) & ((64'h1 << (11 + ps)) - 64'h1)));
    cmd <= {s, off, t, r, k};
    go <= 1'h1;
    @(posedge i_clk);
    go <= 1'h0;
    // Look only after the edge that clears the previous result pulse
    i = 0;
    do
    begin
      @(posedge i_clk) #1;
      i++;
    end
    while (i < 20 && !(o_done || o_fault || o_page_fault));
    if (!(o_done || o_fault || o_page_fault))
    begin
      n_errors++;
      conclude();
    end
    `CHK("done", c == 3'h0, o_done)
    `CHK("fault", c != 3'h0 && c != 3'h5, o_fault)
    `CHK("pfault", c == 3'h5, o_page_fault)
    if (c == 3'h0) `CHK("rma", real_memory_address, o_rma)
    if (c == 3'h0 || c == 3'h5) `CHK("sva", {sy, off}, o_sva)
    if (c != 3'h0) rd(`A_FINFO, {13'h0, c, 4'h0, s});
  endtask
  task automatic phase();
    i_resetn <= 1'h0;
    mon <= 1'h0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'h1;
    `CHK("ready", 1'h0, ready)
    wr(`A_CTRL, 32'h4 | ps);
    `CHK("ready", 1'h0, ready)
    mon <= 1'h1;
    wr(`A_CTRL, 32'h4 | ps);
    `CHK("ready", 1'h1, ready)
    wr(`A_CTRL, 32'h4 | (ps ^ 1));
    rd(`A_CTRL, 32'h4 | ps);
    mon <= 1'h0;
    wr(`A_MASK, 32'h5);
    ce <= 1'h0;
    wr(`A_MASK, 32'h0);
    ce <= 1'h1;
    rd(`A_MASK, 32'h5);
    mon <= 1'h1;
    desc(12'h005, 32'h8100_4444, 16'h0123);
    desc(12'hFFF, 32'h872A_6626, 16'hFEDC);
    map(4'h0, 16'h0123, 31'h0000_1ABC, 17'h00003);
    map(4'hF, 16'hFEDC, 31'h7FFF_FFF0, 17'h00005);
    rd(`A_STAT, 32'h0);
    xl(12'h005, 31'h0000_1ABC, 2'h0, 4'h4, 6'h00, 3'h0);
    `CHK("irq", 1'h1, o_irq)
    rd(`A_STAT, 32'h1);
    `CHK("irq", 1'h0, o_irq)
    xl(12'h005, 31'h0000_1ABC, 2'h0, 4'h5, 6'h00, 3'h3);
    `CHK("irq", 1'h0, o_irq)
    rd(`A_STAT, 32'h2);
    for (int t = 1; t < 4; t++)
      xl(12'h005, 31'h0000_1ABC, 2'(t), 4'h1, 6'h00, 3'h2);
    xl(12'h005, 31'h0000_1ABC, 2'h0, 4'h0, 6'h00, 3'h1);
    desc(12'h00A, 32'h0100_4444, 16'h0123);
    xl(12'h00A, 31'h0000_1ABC, 2'h0, 4'h4, 6'h00, 3'h1);
    for (int t = 0; t < 4; t++)
      xl(12'hFFF, 31'h7FFF_FFF0, 2'(t), 4'h3, 6'h2A, (t == 1) ? 3'h3 : 3'h0);
    xl(12'hFFF, 31'h7FFF_FFF0, 2'h0, 4'h3, 6'h15, 3'h4);
    xl(12'h005, 31'h4000_0000, 2'h0, 4'h4, 6'h00, 3'h5);
    `CHK("irq", 1'h1, o_irq)
    rd(`A_STAT, 32'h7);
    rd(8'h40, 32'h0);
    rd(`A_DIDX, 32'h0);
  endtask
  task automatic desc(input logic [11:0] s, input logic [31:0] lo, input logic [15:0] sy);
    wr(`A_DLO, lo);
    wr(`A_DHI, {16'h0, sy});
    wr(`A_DIDX, {20'h0, s});
  endtask
  initial
  begin
    for (ps = 0; ps < 4; ps++)
      phase();
    conclude();
  end
endmodule
`default_nettype wire

// *** verif/vap_props.sv ***
// Port checker for the translation block
`timescale 1ns/1ps
`default_nettype none
`include "vap_consts.vh"
module vap_props (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic i_req_valid,
  input wire logic [`OFF_W-1:0] i_req_off,
  input wire logic [`RING_W-1:0] i_req_ring,
  input wire logic o_req_ready,
  input wire logic o_done,
  input wire logic o_fault,
  input wire logic o_page_fault,
  input wire logic [`SVA_W-1:0] o_sva,
  input wire logic [`RMA_W-1:0] o_rma,
  input wire logic o_irq
);
  wire tk = i_req_valid && o_req_ready;
  wire ev = o_done || o_fault || o_page_fault;
  logic [`OFF_W-1:0] off_q;
  always @(posedge i_clk)
  begin
    if (tk)
    begin
      off_q <= i_req_off;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  resp_time_a:
    assert property (tk |-> (##2 o_fault) or (##4 (o_done || o_page_fault))) else $error("late answer");
  busy_drop_a:
    assert property (tk |=> !o_req_ready) else $error("ready stayed high");
  one_result_a:
    assert property ($onehot0({o_done, o_fault, o_page_fault})) else $error("two results");
  fault_cause_a:
    assert property (o_fault |-> $past(tk, 2)) else $error("stray fault");
  done_cause_a:
    assert property ((o_done || o_page_fault) |-> $past(tk, 4)) else $error("stray result");
  ring_zero_a:
    assert property (tk && i_req_ring == 4'h0 |-> ##2 o_fault) else $error("ring zero passed");
  sva_off_a:
    assert property (o_done || o_page_fault |-> o_sva[`OFF_W-1:0] == off_q) else $error("sva offset");
  rma_off_a:
    assert property (o_done |-> o_rma[10:0] == off_q[10:0]) else $error("rma offset");
  pf_hold_a:
    assert property (o_page_fault |-> $stable(o_rma)) else $error("rma moved");
  irq_clear_a:
    assert property (i_rd && i_addr == `A_STAT |=> !o_irq || ev) else $error("irq stuck");
endmodule
bind virtual_address_protection vap_props chk (.i_clk, .i_resetn, .i_addr, .i_rd, .i_req_valid, .i_req_off,
  .i_req_ring, .o_req_ready, .o_done, .o_fault, .o_page_fault, .o_sva, .o_rma, .o_irq);
`default_nettype wire
